// ===== hw/fci_device.sv
// Receiver device end: serial data, word ready, steering, carrier detect
// Overview of operation
// - Mark outputs one, space outputs zero
// - Mode 0 streams demodulated bits directly
// - Mode 1 drops start, buffers nine bits
// - Host gives nine shift pulses per byte
// - Ninth shift pulse presents the stop bit
// - Word ready pulses low half bit
// - First mode 1 shift rising edge ends word ready
// - Alert function makes shared pin delayed steering
// - Early steering follows raw tone detector in alert functions
// - Guard sense high asserts steering, low rearms
// - Carrier detect low with dropout hysteresis
// - No words until carrier detect active
// - Function selects choose FSK or alert detection
// - Mode high, selects low: power down
// - Off-hook host selects hybrid alert detection
// - Select encoding: FSK, hybrid, line, reserved
// - Shift clock output in mode 0, input mode 1
`timescale 1ns/1ps
`default_nettype none
module fci_device
    import fci_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    fci_if.device link,
    input wire logic fsk_bit,
    input wire logic fsk_bit_mid,
    input wire logic fsk_signal_present,
    input wire logic tone_detect,
    input wire logic guard_time_sense,
    output logic power_down,
    output logic line_amp_sel,
    output logic hybrid_amp_sel
);
    import fci_pkg::*;
    typedef enum logic [1:0] {
        FCI_RX_IDLE,
        FCI_RX_DATA,
        FCI_RX_STOP
    } fci_rx_t;
    // ==========================================================
    // Input synchronisers
    logic [1:0] mode_s, fa_s, fb_s, sclk_s, gts_s;
    logic mode1, fsk_fn, alert_fn, sclk_rise, sclk_prev_q;
    fci_func_t func;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mode_s <= 2'b00;
            fa_s <= 2'b00;
            fb_s <= 2'b00;
            sclk_s <= 2'b00;
            gts_s <= 2'b00;
            sclk_prev_q <= 1'b0;
        end else begin
            mode_s <= {mode_s[0], link.iface_mode_sel};
            fa_s <= {fa_s[0], link.func_sel_a};
            fb_s <= {fb_s[0], link.func_sel_b};
            sclk_s <= {sclk_s[0], link.serial_shift_clk};
            gts_s <= {gts_s[0], guard_time_sense};
            sclk_prev_q <= sclk_s[1];
        end
    end
    assign mode1 = mode_s[1];
    assign func = fci_func_t'({fa_s[1], fb_s[1]});
    assign fsk_fn = (func == FCI_FN_FSK);
    assign alert_fn = (func == FCI_FN_HYB_ALERT) ||
        (func == FCI_FN_LINE_ALERT);
    assign sclk_rise = mode1 && sclk_s[1] && !sclk_prev_q;
    // ==========================================================
    // Function and power control
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            power_down <= 1'b0;
            line_amp_sel <= 1'b0;
            hybrid_amp_sel <= 1'b0;
        end else begin
            power_down <= mode1 && (func == FCI_FN_RSVD);
            line_amp_sel <= fsk_fn || (func == FCI_FN_LINE_ALERT);
            hybrid_amp_sel <= (func == FCI_FN_HYB_ALERT);
        end
    end
    // ==========================================================
    // Carrier detect with hold-off
    logic [CNT_W-1:0] cd_cnt_q;
    logic cd_q;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cd_cnt_q <= '0;
            cd_q <= 1'b0;
        end else if (!fsk_fn || power_down) begin
            cd_cnt_q <= '0;
            cd_q <= 1'b0;
        end else if (fsk_signal_present) begin
            cd_cnt_q <= CNT_W'(CD_HOLD_CYC);
            cd_q <= 1'b1;
        end else if (cd_cnt_q != '0) begin
            cd_cnt_q <= cd_cnt_q - 1'b1;
        end else begin
            cd_q <= 1'b0;
        end
    end
    // ==========================================================
    // Word framing on the bit-middle strobe
    fci_rx_t rx_q;
    logic [BIT_CNT_W-1:0] bit_q;
    logic [BUF_BITS-1:0] sh_q;
    logic word_v;
    logic word_rdy;
    logic [BUF_BITS-1:0] word_d;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rx_q <= FCI_RX_IDLE;
            bit_q <= '0;
            sh_q <= '0;
        end else if (!cd_q) begin
            rx_q <= FCI_RX_IDLE;
        end else if (fsk_bit_mid) begin
            case (rx_q)
                FCI_RX_IDLE: begin
                    if (fsk_bit == SPACE) begin
                        rx_q <= FCI_RX_DATA;
                        bit_q <= '0;
                    end
                end
                FCI_RX_DATA: begin
                    sh_q <= {fsk_bit, sh_q[BUF_BITS-1:1]};
                    bit_q <= bit_q + 1'b1;
                    if (bit_q == BIT_CNT_W'(WORD_BITS - 1)) begin
                        rx_q <= FCI_RX_STOP;
                    end
                end
                FCI_RX_STOP: begin
                    sh_q <= {fsk_bit, sh_q[BUF_BITS-1:1]};
                    rx_q <= FCI_RX_IDLE;
                end
                default: begin
                    rx_q <= FCI_RX_IDLE;
                end
            endcase
        end
    end
    assign word_v = cd_q && fsk_bit_mid && (rx_q == FCI_RX_STOP);
    assign word_d = {fsk_bit, sh_q[BUF_BITS-1:1]};
    // ==========================================================
    // Word buffer towards the host shifter
    logic buf_v, buf_take;
    logic [BUF_BITS-1:0] buf_d;
    fci_skid #(.W(BUF_BITS)) u_buf (
        .clock(clock),
        .nrst(nrst),
        .in_valid(word_v && mode1),
        .in_ready(word_rdy),
        .in_data(word_d),
        .out_valid(buf_v),
        .out_ready(buf_take),
        .out_data(buf_d)
    );
    // ==========================================================
    // Output shift register and word ready pulse
    logic [BUF_BITS-1:0] out_q;
    logic [BIT_CNT_W-1:0] shift_n_q;
    logic pres_q;
    logic loaded_q;
    logic [CNT_W-1:0] dr_cnt_q;
    logic dr_q;
    // Word held until all nine bits are shifted out
    assign buf_take = !loaded_q;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            out_q <= '0;
            shift_n_q <= '0;
            pres_q <= MARK;
            loaded_q <= 1'b0;
        end else if (buf_v && buf_take) begin
            out_q <= buf_d;
            shift_n_q <= '0;
            loaded_q <= 1'b1;
        end else if (sclk_rise && loaded_q) begin
            pres_q <= out_q[0];
            out_q <= {1'b0, out_q[BUF_BITS-1:1]};
            shift_n_q <= shift_n_q + 1'b1;
            if (shift_n_q == BIT_CNT_W'(BUF_BITS - 1)) begin
                loaded_q <= 1'b0;
            end
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dr_cnt_q <= '0;
            dr_q <= 1'b0;
        end else if (word_v && fsk_fn && (word_rdy || !mode1)) begin
            dr_cnt_q <= CNT_W'(HALF_BIT_CYC);
            dr_q <= 1'b1;
        end else if (sclk_rise) begin
            dr_cnt_q <= '0;
            dr_q <= 1'b0;
        end else if (dr_cnt_q != '0) begin
            dr_cnt_q <= dr_cnt_q - 1'b1;
        end else begin
            dr_q <= 1'b0;
        end
    end
    // ==========================================================
    // Registered pin outputs
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            link.serial_data <= MARK;
            link.shift_clk_dev_o <= 1'b0;
            link.shift_clk_dev_oe <= 1'b0;
            link.word_ready_alert_out_n <= 1'b1;
            link.early_steering <= 1'b0;
            link.carrier_present_n <= 1'b1;
        end else begin
            if (mode1) begin
                link.serial_data <= pres_q;
            end else begin
                link.serial_data <= fsk_bit;
            end
            link.shift_clk_dev_o <= fsk_bit_mid && !mode1;
            link.shift_clk_dev_oe <= !mode1;
            if (alert_fn) begin
                link.word_ready_alert_out_n <= !gts_s[1];
            end else begin
                link.word_ready_alert_out_n <= !dr_q;
            end
            link.early_steering <= alert_fn && tone_detect;
            link.carrier_present_n <= !cd_q;
        end
    end
endmodule
`default_nettype wire

// ===== hw/fci_host.sv
// Host controller end: selects, shift clock and word reader
`timescale 1ns/1ps
`default_nettype none
module fci_host
    import fci_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    fci_if.host link,
    input wire logic cfg_mode,
    input wire logic [1:0] cfg_func,
    output logic [BUF_BITS-1:0] rx_word,
    output logic rx_valid,
    output logic framing_err
);
    import fci_pkg::*;
    typedef enum logic [1:0] {
        FCI_H_IDLE,
        FCI_H_HIGH,
        FCI_H_LOW
    } fci_host_st_t;
    // ==========================================================
    // Synchronisers and word ready edge
    logic [1:0] dr_s, dat_s;
    logic dr_prev_q;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dr_s <= 2'b11;
            dat_s <= 2'b00;
            dr_prev_q <= 1'b1;
        end else begin
            dr_s <= {dr_s[0], link.word_ready_alert_out_n};
            dat_s <= {dat_s[0], link.serial_data};
            dr_prev_q <= dr_s[1];
        end
    end
    // ==========================================================
    // Select drive and shift clock divider
    fci_host_st_t st_q;
    logic [DIV_W-1:0] div_q;
    logic [BIT_CNT_W-1:0] n_q;
    logic [BUF_BITS-1:0] sh_q;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            link.iface_mode_sel <= 1'b0;
            link.func_sel_a <= 1'b1;
            link.func_sel_b <= 1'b1;
            link.shift_clk_host_o <= 1'b0;
            link.shift_clk_host_oe <= 1'b0;
            st_q <= FCI_H_IDLE;
            div_q <= '0;
            n_q <= '0;
            sh_q <= '0;
            rx_word <= '0;
            rx_valid <= 1'b0;
            framing_err <= 1'b0;
        end else begin
            link.iface_mode_sel <= cfg_mode;
            link.func_sel_a <= cfg_func[1];
            link.func_sel_b <= cfg_func[0];
            link.shift_clk_host_oe <= cfg_mode;
            rx_valid <= 1'b0;
            case (st_q)
                FCI_H_IDLE: begin
                    if (cfg_mode && dr_prev_q && !dr_s[1]
                            && cfg_func == 2'b11) begin
                        st_q <= FCI_H_HIGH;
                        n_q <= '0;
                        div_q <= '0;
                    end
                end
                FCI_H_HIGH: begin
                    link.shift_clk_host_o <= 1'b1;
                    div_q <= div_q + 1'b1;
                    if (div_q == DIV_W'(SHIFT_DIV - 1)) begin
                        div_q <= '0;
                        st_q <= FCI_H_LOW;
                    end
                end
                FCI_H_LOW: begin
                    link.shift_clk_host_o <= 1'b0;
                    div_q <= div_q + 1'b1;
                    if (div_q == DIV_W'(SHIFT_DIV - 1)) begin
                        div_q <= '0;
                        sh_q <= {dat_s[1], sh_q[BUF_BITS-1:1]};
                        n_q <= n_q + 1'b1;
                        if (n_q == BIT_CNT_W'(BUF_BITS - 1)) begin
                            rx_word <= {dat_s[1], sh_q[BUF_BITS-1:1]};
                            rx_valid <= 1'b1;
                            framing_err <= (dat_s[1] != MARK);
                            st_q <= FCI_H_IDLE;
                        end else begin
                            st_q <= FCI_H_HIGH;
                        end
                    end
                end
                default: begin
                    st_q <= FCI_H_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== hw/fci_if.sv
// Interface joining the receiver device and the host controller
`timescale 1ns/1ps
`default_nettype none
interface fci_if;
    logic iface_mode_sel;
    logic func_sel_a;
    logic func_sel_b;
    logic serial_data;
    logic shift_clk_dev_o;
    logic shift_clk_dev_oe;
    logic shift_clk_host_o;
    logic shift_clk_host_oe;
    wire logic serial_shift_clk;
    logic word_ready_alert_out_n;
    logic early_steering;
    logic carrier_present_n;
    assign serial_shift_clk = shift_clk_dev_oe ? shift_clk_dev_o :
        (shift_clk_host_oe ? shift_clk_host_o : 1'b0);
    modport device (
        input iface_mode_sel, func_sel_a, func_sel_b, serial_shift_clk,
        output serial_data, shift_clk_dev_o, shift_clk_dev_oe,
        output word_ready_alert_out_n, early_steering, carrier_present_n
    );
    modport host (
        output iface_mode_sel, func_sel_a, func_sel_b,
        output shift_clk_host_o, shift_clk_host_oe,
        input serial_shift_clk, serial_data, word_ready_alert_out_n,
        input early_steering, carrier_present_n
    );
endinterface
`default_nettype wire

// ===== hw/fci_pkg.sv
// Package of shared constants and types for the caller data interface
package fci_pkg;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned BIT_TIME_NS = 833333;
    localparam int unsigned BIT_CYC = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned HALF_BIT_CYC = BIT_CYC / 2;
    localparam int unsigned CD_HOLD_NS = 8000000;
    localparam int unsigned CD_HOLD_CYC = CD_HOLD_NS / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 24;
    localparam int unsigned WORD_BITS = 8;
    localparam int unsigned BUF_BITS = 9;
    localparam int unsigned BIT_CNT_W = 4;
    localparam int unsigned SHIFT_DIV = 4;
    localparam int unsigned DIV_W = 4;
    localparam logic MARK = 1'b1;
    localparam logic SPACE = 1'b0;
    typedef enum logic [1:0] {
        FCI_FN_RSVD,
        FCI_FN_LINE_ALERT,
        FCI_FN_HYB_ALERT,
        FCI_FN_FSK
    } fci_func_t;
endpackage

// ===== hw/fci_skid.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module fci_skid #(
    parameter int unsigned W = 9
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] mem_q [2];
    logic wr_q;
    logic rd_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = (cnt_q != 2'd2);
    assign out_valid = (cnt_q != 2'd0);
    assign out_data = mem_q[rd_q];
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ===== verification/fci_chk.sv
// Checker of the signals on the caller data link
`timescale 1ns/1ps
`default_nettype none
module fci_chk
    import fci_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic iface_mode_sel,
    input wire logic func_sel_a,
    input wire logic func_sel_b,
    input wire logic serial_shift_clk,
    input wire logic shift_clk_dev_o,
    input wire logic shift_clk_dev_oe,
    input wire logic word_ready_alert_out_n,
    input wire logic carrier_present_n
);
    // ==========================================
    // Helper logic and assertions
    localparam int WR_MAX = HALF_BIT_CYC + 2;
    logic [CNT_W-1:0] low_q;
    logic fsk;
    assign fsk = func_sel_a && func_sel_b;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // Length of the current low stretch of word ready
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            low_q <= '0;
        end else begin
            low_q <= word_ready_alert_out_n ? '0 : low_q + CNT_W'(1);
        end
    end
    sequence s_fsk1;
        fsk && iface_mode_sel;
    endsequence
    sequence s_rd;
        !word_ready_alert_out_n && $rose(serial_shift_clk);
    endsequence
    AST_WR_END:
        assert property (s_fsk1 ##0 s_rd |-> ##[1:6] word_ready_alert_out_n)
        else $error("word ready not ended by shift clock");
    AST_WR_MIN:
        assert property (fsk && $fell(word_ready_alert_out_n)
            |=> !word_ready_alert_out_n)
        else $error("word ready pulse too short");
    AST_WR_MAX:
        assert property (fsk |-> low_q <= WR_MAX)
        else $error("word ready low longer than half a bit");
    AST_CD_FIRST:
        assert property (fsk && $fell(word_ready_alert_out_n)
            |-> !carrier_present_n)
        else $error("word flagged without carrier");
    AST_CD_HOLD:
        assert property ($fell(carrier_present_n) |=> !carrier_present_n [*8])
        else $error("carrier detect dropped too soon");
    AST_MODE0_OE:
        assert property ((!iface_mode_sel && fsk) [*6] |-> shift_clk_dev_oe)
        else $error("shift clock not driven in mode 0");
    AST_MODE1_OE:
        assert property (iface_mode_sel [*6] |-> !shift_clk_dev_oe)
        else $error("shift clock driven in mode 1");
    AST_DEV_PULSE:
        assert property (shift_clk_dev_oe && shift_clk_dev_o
            |=> !shift_clk_dev_o [*4])
        else $error("bit middle mark not a single pulse");
endmodule
`default_nettype wire

// ===== verification/fci_tb.sv
// Testbench joining device and host ends of the caller data link
`timescale 1ns/1ps
`default_nettype none
module fci_tb;
    import fci_pkg::*;
    // ==========================================
    // Stimulus and checks
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic fsk_bit = 1'b1;
    logic fsk_bit_mid = 1'b0;
    logic fsk_signal_present = 1'b0;
    logic tone_detect = 1'b0;
    logic guard_time_sense = 1'b0;
    logic cfg_mode = 1'b1;
    logic [1:0] cfg_func = 2'b11;
    logic power_down, line_amp_sel, hybrid_amp_sel, rx_valid, framing_err;
    logic [BUF_BITS-1:0] rx_word;
    logic [BUF_BITS-1:0] got_q[$];
    logic [BUF_BITS-1:0] exp_q[$];
    logic [7:0] d;
    int n_errors = 0;
    int cmp_count = 0;
    int seed = 67;
    int cyc = 0;
    int falls = 0;
    int pulses = 0;
    int p0 = 0;
    fci_if link_if();
    fci_device fci_device_inst (.clock(clock), .nrst(nrst), .link(link_if),
        .fsk_bit(fsk_bit), .fsk_bit_mid(fsk_bit_mid),
        .fsk_signal_present(fsk_signal_present), .tone_detect(tone_detect),
        .guard_time_sense(guard_time_sense), .power_down(power_down),
        .line_amp_sel(line_amp_sel), .hybrid_amp_sel(hybrid_amp_sel));
    fci_host fci_host_inst (.clock(clock), .nrst(nrst), .link(link_if),
        .cfg_mode(cfg_mode), .cfg_func(cfg_func), .rx_word(rx_word),
        .rx_valid(rx_valid), .framing_err(framing_err));
    fci_chk fci_chk_inst (.clock(clock), .nrst(nrst),
        .iface_mode_sel(link_if.iface_mode_sel),
        .func_sel_a(link_if.func_sel_a), .func_sel_b(link_if.func_sel_b),
        .serial_shift_clk(link_if.serial_shift_clk),
        .shift_clk_dev_o(link_if.shift_clk_dev_o),
        .shift_clk_dev_oe(link_if.shift_clk_dev_oe),
        .word_ready_alert_out_n(link_if.word_ready_alert_out_n),
        .carrier_present_n(link_if.carrier_present_n));
    always #2.5 clock = ~clock;
    always @(negedge clock) begin
        cyc++;
        if (rx_valid === 1'b1) begin
            got_q.push_back(rx_word);
        end
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    always @(negedge link_if.word_ready_alert_out_n) falls++;
    always @(posedge link_if.serial_shift_clk) pulses++;
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic send_bit(input logic b);
        fsk_bit = b;
        tick(5);
        fsk_bit_mid = 1'b1;
        tick(1);
        fsk_bit_mid = 1'b0;
        tick(6);
    endtask
    task automatic send_word(input logic [7:0] v, input logic stop);
        send_bit(SPACE);
        for (int i = 0; i < WORD_BITS; i++) begin
            send_bit(v[i]);
        end
        send_bit(stop);
    endtask
    function automatic logic [8:0] exp_word(input logic [7:0] v,
        input logic stop);
        return {stop, v};
    endfunction
    initial begin
        tick(2);
        nrst = 1'b1;
        tick(1);
        chk(link_if.serial_data, MARK);
        chk(link_if.word_ready_alert_out_n, 1'b1);
        chk(link_if.carrier_present_n, 1'b1);
        tick(8);
        send_word(8'h5a, MARK);
        tick(100);
        chk(9'(got_q.size()), 9'h0);
        chk(9'(falls), 9'h0);
        fsk_signal_present = 1'b1;
        for (int i = 0; i < 200 && link_if.carrier_present_n !== 1'b0; i++) begin
            tick(1);
        end
        chk(link_if.carrier_present_n, 1'b0);
        fsk_signal_present = 1'b0;
        for (int i = 0; i < 40; i++) begin
            tick(1);
            chk(link_if.carrier_present_n, 1'b0);
        end
        fsk_signal_present = 1'b1;
        p0 = pulses;
        for (int i = 0; i < 12; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            exp_q.push_back(exp_word(d, i != 11));
            send_word(d, i != 11);
        end
        tick(200);
        chk(9'(got_q.size()), 9'h00c);
        foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
        chk(framing_err, 1'b1);
        chk(9'(falls), 9'h00c);
        chk(9'(pulses - p0), 9'h06c);
        for (int f = 1; f < 3; f++) begin
            cfg_func = 2'(f);
            tick(10);
            chk({line_amp_sel, hybrid_amp_sel}, {f == 1, f == 2});
            guard_time_sense = 1'b1;
            tick(8);
            chk(link_if.word_ready_alert_out_n, 1'b0);
            guard_time_sense = 1'b0;
            tick(8);
            chk(link_if.word_ready_alert_out_n, 1'b1);
            repeat (6) begin
                tone_detect = 1'($random(seed));
                tick(4);
                chk(link_if.early_steering, tone_detect);
            end
            tone_detect = 1'b0;
        end
        cfg_func = 2'b11;
        tick(10);
        chk({line_amp_sel, hybrid_amp_sel}, 2'b10);
        chk(power_down, 1'b0);
        cfg_func = 2'b00;
        tick(10);
        chk(power_down, 1'b1);
        cfg_func = 2'b11;
        cfg_mode = 1'b0;
        tick(10);
        p0 = falls;
        send_word(8'h3c, MARK);
        tick(3);
        chk(link_if.word_ready_alert_out_n, 1'b0);
        chk(9'(falls - p0), 9'h001);
        p0 = pulses;
        for (int i = 0; i < 10; i++) begin
            send_bit(1'($random(seed)));
            chk(link_if.serial_data, fsk_bit);
        end
        chk(9'(pulses - p0), 9'h00a);
        stop_test();
    end
endmodule
`default_nettype wire
